// >>> core/sscd_top.sv
`timescale 1ns/100ps
module sscd_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic gen1_compat_n,
  input wire logic serial_cfg_hold_n,
  input wire logic smb_select_n,
  input wire logic nontransp_bridge_en_n,
  input wire logic clk_pll_skip_n,
  input wire logic nontransp_func_en_n,
  input wire logic [sscd_pkg::PORT_SEL_W-1:0] nontransp_port_sel,
  input wire logic [sscd_pkg::PORT_SEL_W-1:0] up_port_sel,
  input wire logic [2*sscd_pkg::STATIONS-1:0] station_lane_cfg,
  input wire logic [sscd_pkg::VS_W-1:0] virt_switch_count,
  input wire logic [sscd_pkg::FUNC_W-1:0] ball_function_sel,
  input wire logic [1:0] rsv_strap_lo,
  input wire logic rsv_strap_gnd,
  input wire logic train_fail,
  input wire logic detect_exit,
  input wire logic cfg_release,
  input wire logic [sscd_pkg::PORTS-1:0] port_ok_in,
  input wire logic [sscd_pkg::PORTS-1:0] gpio_shared_out,
  input wire logic [sscd_pkg::GPIO_DED-1:0] gpio_ded_out,
  input wire logic [sscd_pkg::GPIO_DED-1:0] slot_reset_req,
  output logic adv_gen2,
  output logic adv_autonomous,
  output logic train_enable,
  output logic smb_mode,
  output logic nontransp_bridge_on,
  output logic pll_bypass,
  output logic nontransp_on,
  output logic [sscd_pkg::PORT_SEL_W-1:0] up_port,
  output logic [sscd_pkg::PORT_SEL_W-1:0] nontransp_port,
  output logic [3*sscd_pkg::STATIONS-1:0] station_ports,
  output logic [5*sscd_pkg::STATIONS-1:0] station_width,
  output logic [sscd_pkg::VS_W-1:0] vs_count,
  output logic single_switch,
  output logic func_invalid,
  output logic rsv_bad,
  output logic [sscd_pkg::PORTS-1:0] port_ok_n,
  output logic [sscd_pkg::PORTS-1:0] gpio_shared_oe_n,
  output logic [sscd_pkg::GPIO_DED-1:0] gpio_ded_o,
  output logic [sscd_pkg::GPIO_DED-1:0] gpio_ded_oe_n
);
  import sscd_pkg::*;

  localparam int SW = 9 + 2*PORT_SEL_W + 2*STATIONS + VS_W + FUNC_W;

  // ****************************************
  // strap synchronisers and capture
  // ****************************************
  // straps are pins: two flops before any use
  logic [SW-1:0] pin_raw, s1_reg, s1_next, s2_reg, s2_next;
  logic [SW-1:0] cap_reg, cap_next;
  // undriven straps reach these pins at their pad pull level
  assign pin_raw = {gen1_compat_n, serial_cfg_hold_n, smb_select_n,
    nontransp_bridge_en_n, clk_pll_skip_n, nontransp_func_en_n,
    nontransp_port_sel, up_port_sel, station_lane_cfg, virt_switch_count,
    ball_function_sel, rsv_strap_lo, rsv_strap_gnd};

  // capture follows pins only while reset is high, then freezes
  always_comb begin
    s1_next = pin_raw;
    s2_next = s1_reg;
    cap_next = reset ? s2_reg : cap_reg;
  end
  always_ff @(posedge clk) begin
    s1_reg <= s1_next;
    s2_reg <= s2_next;
    cap_reg <= cap_next;
  end

  logic c_gen1, c_hold, c_smb, c_br, c_pll, c_nt;
  logic [PORT_SEL_W-1:0] c_ntsel, c_upsel;
  logic [2*STATIONS-1:0] c_lane;
  logic [VS_W-1:0] c_vs;
  logic [FUNC_W-1:0] c_func;
  logic [1:0] c_rlo;
  logic c_rgnd;
  assign {c_gen1, c_hold, c_smb, c_br, c_pll, c_nt, c_ntsel, c_upsel,
    c_lane, c_vs, c_func, c_rlo, c_rgnd} = cap_reg;

  // ****************************************
  // link rate advertisement and training hold
  // ****************************************
  logic fail_reg, fail_next, g1_reg, g1_next, rel_reg, rel_next;
  always_comb begin
    fail_next = fail_reg;
    g1_next = g1_reg;
    rel_next = rel_reg | cfg_release;
    if (train_fail && !c_gen1) begin
      fail_next = 1'b1;
    end
    if (detect_exit && (fail_reg || (train_fail && !c_gen1))) begin
      g1_next = 1'b1;
    end
    if (c_gen1) begin
      fail_next = 1'b0;
      g1_next = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      fail_reg <= 1'b0;
      g1_reg <= 1'b0;
      rel_reg <= 1'b0;
    end else begin
      fail_reg <= fail_next;
      g1_reg <= g1_next;
      rel_reg <= rel_next;
    end
  end

  // ****************************************
  // decoded configuration outputs
  // ****************************************
  logic [3*STATIONS-1:0] sp_next;
  logic [5*STATIONS-1:0] swd_next;
  genvar st;
  generate
    for (st = 0; st < STATIONS; st++) begin : g_stn
      always_comb begin
        unique case (c_lane[2*st +: 2])
          LANE_4X4: begin
            sp_next[3*st +: 3] = NPORT_4X4;
            swd_next[5*st +: 5] = WIDE_4;
          end
          LANE_1X16: begin
            sp_next[3*st +: 3] = NPORT_1X16;
            swd_next[5*st +: 5] = WIDE_16;
          end
          LANE_2X8: begin
            sp_next[3*st +: 3] = NPORT_2X8;
            swd_next[5*st +: 5] = WIDE_8;
          end
          LANE_8X4X4: begin
            sp_next[3*st +: 3] = NPORT_8X4X4;
            swd_next[5*st +: 5] = WIDE_8;
          end
        endcase
      end
    end
  endgenerate

  // 0ch and 0dh both give port-good and slot reset use of the balls
  logic hp_mode, norm_mode;
  assign norm_mode = (c_func == FUNC_NORMAL) || (c_func == FUNC_HP_A);
  assign hp_mode = norm_mode;

  logic [PORTS-1:0] pok_next, shoe_next;
  logic [GPIO_DED-1:0] dedo_next, dedoe_next;
  always_comb begin
    // shared balls: port-good outputs in standard operation
    pok_next = norm_mode ? ~port_ok_in : gpio_shared_out;
    shoe_next = {PORTS{c_func == FUNC_INVALID}};
    // dedicated balls: slot resets in hot-plug modes
    dedo_next = hp_mode ? ~slot_reset_req : gpio_ded_out;
    dedoe_next = {GPIO_DED{1'b0}};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      adv_gen2 <= 1'b0;
      adv_autonomous <= 1'b0;
      train_enable <= 1'b0;
      smb_mode <= 1'b0;
      nontransp_bridge_on <= 1'b0;
      pll_bypass <= 1'b0;
      nontransp_on <= 1'b0;
      up_port <= '0;
      nontransp_port <= '0;
      station_ports <= '0;
      station_width <= '0;
      vs_count <= '0;
      single_switch <= 1'b0;
      func_invalid <= 1'b0;
      rsv_bad <= 1'b0;
      port_ok_n <= '1;
      gpio_shared_oe_n <= '1;
      gpio_ded_o <= '1;
      gpio_ded_oe_n <= '1;
    end else begin
      adv_gen2 <= !g1_reg;
      adv_autonomous <= !g1_reg;
      train_enable <= c_hold || rel_reg;
      smb_mode <= !c_smb;
      nontransp_bridge_on <= !c_br;
      pll_bypass <= !c_pll;
      nontransp_on <= !c_nt;
      up_port <= c_upsel;
      nontransp_port <= c_ntsel;
      station_ports <= sp_next;
      station_width <= swd_next;
      vs_count <= c_vs;
      single_switch <= (c_vs == VS_SINGLE);
      func_invalid <= (c_func == FUNC_INVALID);
      rsv_bad <= (c_rlo != 2'h0) || c_rgnd;
      port_ok_n <= pok_next;
      gpio_shared_oe_n <= shoe_next;
      gpio_ded_o <= dedo_next;
      gpio_ded_oe_n <= dedoe_next;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_hold_blocks: assert property (@(posedge clk) disable iff (reset)
    (!c_hold && !rel_reg) |=> !train_enable)
    else $error("training enabled while held");
  a_gen1_fallback: assert property (@(posedge clk) disable iff (reset)
    (!c_gen1 && detect_exit && (train_fail || fail_reg)) |=> ##1 !adv_gen2)
    else $error("no first-generation fallback");
  a_gen2_always: assert property (@(posedge clk) disable iff (reset)
    c_gen1 ##1 c_gen1 |=> adv_gen2 && adv_autonomous)
    else $error("second generation not advertised");
  a_cap_frozen: assert property (@(posedge clk)
    !reset |=> $stable(cap_reg))
    else $error("strap capture changed outside reset");
  a_smb_select: assert property (@(posedge clk) disable iff (reset)
    $past(!reset) |-> smb_mode == !$past(c_smb))
    else $error("protocol select wrong");
  a_single_sw: assert property (@(posedge clk) disable iff (reset)
    (c_vs == VS_SINGLE) |=> single_switch && vs_count == VS_SINGLE)
    else $error("single switch mode wrong");
  a_nt_enable: assert property (@(posedge clk) disable iff (reset)
    !c_nt |=> nontransp_on && nontransp_port == $past(c_ntsel))
    else $error("non-transparent select wrong");
  a_pll_skip: assert property (@(posedge clk) disable iff (reset)
    c_pll |=> !pll_bypass)
    else $error("pll bypassed with strap high");
  a_bridge_on: assert property (@(posedge clk) disable iff (reset)
    !c_br |=> nontransp_bridge_on)
    else $error("bridge not enabled");
endmodule

// >>> core/sscd_pkg.sv
// Function
// - strap high: advertise second-generation rate and autonomous change
// - low strap, failed training: next detect exit advertises gen1 only
// - hold strap low: links wait for the serial initiate-configuration bit
// - select strap low picks SMBus, high picks plain I2C on slave port 0
// - bridge strap low enables the non-transparent bridge, high disables it
// - bypass strap low bypasses the internal clock PLL
// - six stations decode two-bit lane grouping into port widths
// - three-bit field gives virtual switch count; zero means single switch
// - five-bit field selects port-good and GPIO 24..42 use; GPIO 24..42 drive as outputs in every mode once out of reset
// - 43 GPIO: 19 dedicated, 24 shared with active-low port-good outputs
// - undriven straps fall to internal pull defaults
// - upstream and non-transparent port fields; active-low function enable
package sscd_pkg;
  localparam int STATIONS = 6;
  localparam int PORT_SEL_W = 5;
  localparam int VS_W = 3;
  localparam int FUNC_W = 5;
  localparam int PORTS = 24;
  localparam int GPIO_DED = 19;
  localparam int GPIO_TOTAL = 43;
  localparam logic [VS_W-1:0] VS_SINGLE = 3'h0;
  localparam logic [FUNC_W-1:0] FUNC_INVALID = 5'h00;
  localparam logic [FUNC_W-1:0] FUNC_HP_A = 5'h0c;
  localparam logic [FUNC_W-1:0] FUNC_NORMAL = 5'h0d;
  localparam logic [1:0] LANE_4X4 = 2'h0;
  localparam logic [1:0] LANE_1X16 = 2'h1;
  localparam logic [1:0] LANE_2X8 = 2'h2;
  localparam logic [1:0] LANE_8X4X4 = 2'h3;
  // per station: ports used, width of widest port
  localparam logic [2:0] NPORT_4X4 = 3'h4;
  localparam logic [2:0] NPORT_1X16 = 3'h1;
  localparam logic [2:0] NPORT_2X8 = 3'h2;
  localparam logic [2:0] NPORT_8X4X4 = 3'h3;
  localparam logic [4:0] WIDE_4 = 5'h04;
  localparam logic [4:0] WIDE_8 = 5'h08;
  localparam logic [4:0] WIDE_16 = 5'h10;
endpackage

// >>> verif/sscd_board.sv
`timescale 1ns/100ps
// ****************************************
// board straps and serial config master
// ****************************************
module sscd_board (
  input wire logic [5:0] flags,
  input wire logic [4:0] fn,
  input wire logic rel,
  output logic gen1_compat_n,
  output logic serial_cfg_hold_n,
  output logic smb_select_n,
  output logic nontransp_bridge_en_n,
  output logic clk_pll_skip_n,
  output logic nontransp_func_en_n,
  output logic [4:0] ball_function_sel,
  output logic [1:0] rsv_strap_lo,
  output logic rsv_strap_gnd,
  output logic cfg_release
);
  assign {gen1_compat_n, serial_cfg_hold_n, smb_select_n} = flags[5:3];
  assign {nontransp_bridge_en_n, clk_pll_skip_n} = flags[2:1];
  assign nontransp_func_en_n = flags[0];
  // zero is never fitted; fall back to the normal pull-up pattern
  assign ball_function_sel = (fn == 5'h00) ? 5'h0d : fn;
  assign rsv_strap_lo = 2'h0;
  assign rsv_strap_gnd = 1'b0;
  // master writes the initiate bit once; device keeps it sticky
  assign cfg_release = rel;
endmodule

// >>> verif/sscd_top_bench.sv
`timescale 1ns/100ps
// ****************************************
// strap decoder bench
// ****************************************
module sscd_top_bench;
  import sscd_pkg::*;
  typedef struct packed {
    logic [5:0] fl;
    logic [11:0] ln;
    logic [2:0] vs;
    logic [4:0] fn;
    logic [4:0] up;
    logic [4:0] ex;
  } sscd_row_type;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] fl = 6'h3f;
  logic [4:0] fn = 5'h0d;
  logic [4:0] up = 5'h00;
  logic [11:0] ln = 12'h000;
  logic [2:0] vs = 3'h0;
  logic rel = 1'b0;
  logic train_fail = 1'b0;
  logic detect_exit = 1'b0;
  logic [23:0] ok_in = 24'h5a3c96;
  logic [23:0] sh_out = 24'h0f0f0f;
  logic [18:0] ded_out = 19'h2a5a5;
  logic [18:0] srst = 19'h12345;
  logic g1_n, hold_n, smb_n, br_n, pll_n, ntf_n, rsv_gnd, cfg_rel;
  logic [4:0] fsel;
  logic [1:0] rsv_lo;
  logic adv_gen2, adv_auto, train_en, smb, br_on, pll_byp, nt_on;
  logic [4:0] up_port, nt_port;
  logic [17:0] st_p;
  logic [29:0] st_w;
  logic [2:0] vsc;
  logic single, finv, rbad;
  logic [23:0] pok_n, sh_oe_n;
  logic [18:0] ded_o, ded_oe_n;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [1:0] lc;
  sscd_row_type rows [4] = '{
    '{6'h3f, 12'h000, 3'h0, 5'h0d, 5'h00, 5'h10},
    '{6'h20, 12'h0e4, 3'h5, 5'h0c, 5'h17, 5'h0f},
    '{6'h2a, 12'hfff, 3'h7, 5'h05, 5'h1f, 5'h05},
    '{6'h1f, 12'hb1e, 3'h1, 5'h0d, 5'h0a, 5'h10}};

  sscd_board i_sscd_board (.flags(fl), .fn(fn), .rel(rel),
    .gen1_compat_n(g1_n), .serial_cfg_hold_n(hold_n),
    .smb_select_n(smb_n), .nontransp_bridge_en_n(br_n),
    .clk_pll_skip_n(pll_n), .nontransp_func_en_n(ntf_n),
    .ball_function_sel(fsel), .rsv_strap_lo(rsv_lo),
    .rsv_strap_gnd(rsv_gnd), .cfg_release(cfg_rel));
  sscd_top i_sscd_top (.clk(clk), .reset(reset), .gen1_compat_n(g1_n),
    .serial_cfg_hold_n(hold_n), .smb_select_n(smb_n),
    .nontransp_bridge_en_n(br_n), .clk_pll_skip_n(pll_n),
    .nontransp_func_en_n(ntf_n), .nontransp_port_sel(~up),
    .up_port_sel(up), .station_lane_cfg(ln), .virt_switch_count(vs),
    .ball_function_sel(fsel), .rsv_strap_lo(rsv_lo),
    .rsv_strap_gnd(rsv_gnd), .train_fail(train_fail),
    .detect_exit(detect_exit), .cfg_release(cfg_rel),
    .port_ok_in(ok_in), .gpio_shared_out(sh_out),
    .gpio_ded_out(ded_out), .slot_reset_req(srst), .adv_gen2(adv_gen2),
    .adv_autonomous(adv_auto), .train_enable(train_en), .smb_mode(smb),
    .nontransp_bridge_on(br_on), .pll_bypass(pll_byp),
    .nontransp_on(nt_on), .up_port(up_port), .nontransp_port(nt_port),
    .station_ports(st_p), .station_width(st_w), .vs_count(vsc),
    .single_switch(single), .func_invalid(finv), .rsv_bad(rbad),
    .port_ok_n(pok_n), .gpio_shared_oe_n(sh_oe_n), .gpio_ded_o(ded_o),
    .gpio_ded_oe_n(ded_oe_n));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ports used and widest port per lane grouping code
  function automatic logic [7:0] lane_exp(input logic [1:0] c);
    case (c)
      2'h0: return {3'h4, 5'h04};
      2'h1: return {3'h1, 5'h10};
      2'h2: return {3'h2, 5'h08};
      default: return {3'h3, 5'h08};
    endcase
  endfunction

  // straps settle across the synchroniser while reset is held
  task automatic apply(input sscd_row_type r);
    @(posedge clk);
    #1;
    reset = 1'b1;
    {fl, ln, vs, fn, up} = {r.fl, r.ln, r.vs, r.fn, r.up};
    repeat (4) @(posedge clk);
    #1;
    chk({adv_gen2, train_en, pok_n}, {2'h0, 24'hffffff});
    reset = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic fail_seq;
    train_fail = 1'b1;
    @(posedge clk);
    #1;
    train_fail = 1'b0;
    detect_exit = 1'b1;
    @(posedge clk);
    #1;
    detect_exit = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      apply(rows[i]);
      chk({train_en, smb}, rows[i].ex[4:3]);
      chk({br_on, pll_byp, nt_on}, rows[i].ex[2:0]);
      chk({adv_gen2, adv_auto}, 2'h3);
      chk({up_port, nt_port}, {rows[i].up, ~rows[i].up});
      chk({vsc, single}, {rows[i].vs, rows[i].vs == 3'h0});
      chk({rbad, finv}, 2'h0);
      for (int s = 0; s < 6; s++) begin
        lc = rows[i].ln[2*s+:2];
        chk({st_p[3*s+:3], st_w[5*s+:5]}, lane_exp(lc));
      end
      if (rows[i].fn == 5'h05) begin
        chk({pok_n, sh_oe_n}, {sh_out, 24'h0});
        chk({ded_o, ded_oe_n}, {ded_out, 19'h0});
      end else begin
        chk({pok_n, sh_oe_n}, {~ok_in, 24'h0});
        chk({ded_o, ded_oe_n}, {~srst, 19'h0});
      end
    end
    apply(rows[0]);
    fl = 6'h00;
    up = 5'h1f;
    repeat (4) @(posedge clk);
    #1;
    chk({smb, up_port, train_en}, {1'b0, 5'h00, 1'b1});
    apply(rows[1]);
    rel = 1'b1;
    @(posedge clk);
    #1;
    rel = 1'b0;
    @(posedge clk);
    #1;
    chk(train_en, 1'b1);
    apply(rows[0]);
    fail_seq();
    chk({adv_gen2, adv_auto}, 2'h3);
    apply(rows[3]);
    fail_seq();
    chk({adv_gen2, adv_auto}, 2'h0);
    complete_run();
  end
endmodule
